// ===== hw/bfp_pkg.sv
// Package of constants and types for the burst flash host port
package bfp_pkg;
  // Address and data widths of the host pins
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned DATA_W = 16;
  // Initial burst latency, in active link clock edges
  localparam logic [3:0] LAT_STD_EDGES = 4'h7;
  localparam logic [3:0] LAT_RED_EDGES = 4'h5;
  // Values after reset
  localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [3:0] LAT_RST = 4'h0;
  // Levels seen on the acceleration pin
  typedef enum logic [1:0] {
    ACC_LOW  = 2'b00,
    ACC_HIGH = 2'b01,
    ACC_ELEV = 2'b10
  } bfp_acc_type;
  // Read-side states
  typedef enum logic [1:0] {
    ST_READ_ARRAY = 2'b00,
    ST_WAIT       = 2'b01,
    ST_BURST      = 2'b10
  } bfp_state_type;
endpackage : bfp_pkg

// ===== hw/bfp_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module bfp_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : bfp_sync
`default_nettype wire

// ===== hw/bfp_port.sv
// Device-side pin logic of the burst flash host port
// Behaviour
// - In a burst, ready is low until valid data is presented and high while it is valid.
// - Asynchronous reads work with the link clock standing still; the clock is ignored then.
// - In a burst, after the first word each active clock edge steps the burst address.
// - In asynchronous mode a low address strobe marks the address inputs as valid.
// - In burst mode the rising edge of the address strobe loads the burst start address.
// - With the address strobe high, address inputs are ignored.
// - A low hardware reset returns all state to read-array.
// - A low write-protect refuses program and erase on the two outermost sectors.
// - Elevated acceleration speeds programming and enters unlock bypass; low locks all sectors.
// - Chip enable going high ends a burst at any clock phase.
// - Output enable gates the data outputs independently of clock edges.
// - Reduced handshaking shortens the initial latency for even start addresses only.
// - The address is captured on the rising edge of the address strobe.
// - After reset the state machine rests in read-array, altering nothing.
`timescale 1ns/1ps
`default_nettype none
module bfp_port
  import bfp_pkg::*;
#(
  parameter bit          REDUCED_WAIT = 1'b1,
  parameter logic [3:0]  LAT_STD      = bfp_pkg::LAT_STD_EDGES,
  parameter logic [3:0]  LAT_RED      = bfp_pkg::LAT_RED_EDGES
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_i,
  input  wire logic                      link_clk_i,
  input  wire logic                      chip_en_n_i,
  input  wire logic                      out_en_n_i,
  input  wire logic                      write_en_n_i,
  input  wire logic                      addr_valid_strobe_n_i,
  input  wire logic [bfp_pkg::ADDR_W-1:0] word_addr_i,
  input  wire logic                      hw_reset_n_i,
  input  wire logic                      write_protect_n_i,
  input  wire logic [1:0]                acc_level_i,
  input  wire logic                      burst_mode_i,
  input  wire logic [bfp_pkg::DATA_W-1:0] array_rdata_i,
  input  wire logic                      prog_req_i,
  input  wire logic                      prog_outer_i,
  output logic      [bfp_pkg::ADDR_W-1:0] array_addr_o,
  output logic      [bfp_pkg::DATA_W-1:0] data_bus_o,
  output logic                           data_bus_oe_n_o,
  output logic                           rdy_o,
  output logic                           read_array_o,
  output logic                           prog_grant_o,
  output logic                           prog_accel_o,
  output logic                           unlock_bypass_o
);
  import bfp_pkg::*;

  // Address pins plus nine control pins (the acceleration level counts as two)
  localparam int unsigned PIN_W = ADDR_W + 9;

  logic [PIN_W-1:0]  pins_s;
  logic              lclk_s;
  logic              ce_n_s;
  logic              oe_n_s;
  logic              we_n_s;
  logic              avd_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic              hwrst_n_s;
  logic              wp_n_s;
  logic [1:0]        acc_s;
  logic              lclk_q;
  logic              avd_n_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [3:0]        lat_q;
  logic [3:0]        lat_d;
  bfp_state_type     state_q;
  bfp_state_type     state_d;
  logic [DATA_W-1:0] data_q;
  logic              oe_n_q;
  logic              rdy_q;
  logic              grant_q;
  logic              accel_q;
  logic              bypass_q;
  logic              read_array_q;

  // Every pin passes two flops; idle levels are the inactive ones
  bfp_sync #(
    .WIDTH   (PIN_W),
    .RST_VAL ({1'b0, 4'hF, {ADDR_W{1'b0}}, 2'b11, 2'b01})
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   ({link_clk_i, chip_en_n_i, out_en_n_i, write_en_n_i,
                 addr_valid_strobe_n_i, word_addr_i, hw_reset_n_i,
                 write_protect_n_i, acc_level_i}),
    .sync_o    (pins_s)
  );

  // Field split of the synchronised pins
  assign {lclk_s, ce_n_s, oe_n_s, we_n_s, avd_n_s, addr_s, hwrst_n_s, wp_n_s, acc_s} = pins_s;

  // Decoded events
  wire clr_all   = rst_i | ~hwrst_n_s;
  wire lclk_edge = lclk_s & ~lclk_q;                    // Rising active edge
  wire avd_rise  = avd_n_s & ~avd_n_q & ~ce_n_s;
  wire start_odd = addr_s[0];
  wire [3:0] lat_start = (REDUCED_WAIT && !start_odd) ? LAT_RED : LAT_STD;
  wire lock_all  = (bfp_acc_type'(acc_s) == ACC_LOW);
  wire outer_blk = ~wp_n_s & prog_outer_i;
  wire drive_en  = ~ce_n_s & ~oe_n_s & we_n_s;

  // Next address, latency and state
  always_comb
  begin
    state_d = state_q;
    addr_d  = addr_q;
    lat_d   = lat_q;
    unique case (state_q)
      ST_READ_ARRAY:
      begin
        if (!burst_mode_i && !avd_n_s && !ce_n_s)
          addr_d = addr_s;
        if (avd_rise)
        begin
          addr_d = addr_s;
          if (burst_mode_i)
          begin
            lat_d   = lat_start;
            state_d = ST_WAIT;
          end
        end
      end
      ST_WAIT:
      begin
        if (lclk_edge)
        begin
          lat_d = lat_q - 4'h1;
          if (lat_q == 4'h1)
            state_d = ST_BURST;
        end
      end
      ST_BURST:
      begin
        if (lclk_edge)
          addr_d = addr_q + 21'h000001;
      end
      default:
        state_d = ST_READ_ARRAY;
    endcase
    if (ce_n_s && state_q != ST_READ_ARRAY)
      state_d = ST_READ_ARRAY;
    else if (avd_rise && state_q != ST_READ_ARRAY && burst_mode_i)
    begin
      addr_d  = addr_s;                                 // Restart burst
      lat_d   = lat_start;
      state_d = ST_WAIT;
    end
  end

  // Read-side state; reset returns to read-array
  always_ff @(posedge clk_sys_i)
  begin
    if (clr_all)
    begin
      state_q <= ST_READ_ARRAY;
      addr_q  <= ADDR_RST;
      lat_q   <= LAT_RST;
      lclk_q  <= 1'b0;
      avd_n_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      addr_q  <= addr_d;
      lat_q   <= lat_d;
      lclk_q  <= lclk_s;
      avd_n_q <= avd_n_s;
    end
  end

  // Output flops; ready follows the data valid state
  always_ff @(posedge clk_sys_i)
  begin
    if (clr_all)
    begin
      data_q   <= DATA_RST;
      oe_n_q   <= 1'b1;
      rdy_q    <= 1'b0;
      grant_q  <= 1'b0;
      accel_q  <= 1'b0;
      bypass_q <= 1'b0;
      read_array_q <= 1'b1;
    end
    else
    begin
      data_q   <= array_rdata_i;
      oe_n_q   <= ~drive_en;
      rdy_q    <= (state_d == ST_BURST) | ~burst_mode_i;
      grant_q  <= prog_req_i & ~lock_all & ~outer_blk;
      accel_q  <= (bfp_acc_type'(acc_s) == ACC_ELEV);
      bypass_q <= (bfp_acc_type'(acc_s) == ACC_ELEV);
      read_array_q <= (state_d == ST_READ_ARRAY);       // Flop copy of the idle decode
    end
  end

  assign array_addr_o    = addr_q;
  assign data_bus_o      = data_q;
  assign data_bus_oe_n_o = oe_n_q;
  assign rdy_o           = rdy_q;
  assign read_array_o    = read_array_q;
  assign prog_grant_o    = grant_q;
  assign prog_accel_o    = accel_q;
  assign unlock_bypass_o = bypass_q;

  // Checks on the state machine and outputs
  sequence s_burst_start;
    avd_rise && burst_mode_i && !ce_n_s;
  endsequence

  // The last latency edge legitimately raises ready, so it is left out here
  a_rdy_in_wait: assert property (@(posedge clk_sys_i) disable iff (clr_all)
    (state_q == ST_WAIT && burst_mode_i && !ce_n_s && !avd_rise
      && !(lclk_edge && lat_q == 4'h1)) |=> !rdy_o)
    else $error("ready high during initial latency");
  a_burst_enters_wait: assert property (@(posedge clk_sys_i) disable iff (clr_all)
    s_burst_start |=> state_q == ST_WAIT && array_addr_o == $past(addr_s))
    else $error("burst start not loaded");
  a_addr_step: assert property (@(posedge clk_sys_i) disable iff (clr_all)
    (state_q == ST_BURST && lclk_edge && !ce_n_s && !avd_rise)
      |=> array_addr_o == $past(array_addr_o) + 21'h000001)
    else $error("burst address did not step");
  a_addr_hold: assert property (@(posedge clk_sys_i) disable iff (clr_all)
    (state_q == ST_READ_ARRAY && avd_n_s && avd_n_q) |=> $stable(array_addr_o))
    else $error("address moved with strobe high");
  a_ce_ends_burst: assert property (@(posedge clk_sys_i) disable iff (clr_all)
    (ce_n_s && state_q != ST_READ_ARRAY) |=> read_array_o)
    else $error("chip enable did not end burst");
  a_oe_gates_data: assert property (@(posedge clk_sys_i) disable iff (clr_all)
    oe_n_s |=> data_bus_oe_n_o)
    else $error("data driven with output enable high");
  a_even_latency: assert property (@(posedge clk_sys_i) disable iff (clr_all)
    (s_burst_start and !start_odd) |=> lat_q == (REDUCED_WAIT ? LAT_RED : LAT_STD))
    else $error("wrong even start latency");
  a_odd_latency: assert property (@(posedge clk_sys_i) disable iff (clr_all)
    (s_burst_start and start_odd) |=> lat_q == LAT_STD)
    else $error("wrong odd start latency");
  a_reset_state: assert property (@(posedge clk_sys_i)
    (!hwrst_n_s && !rst_i) |=> read_array_o && !rdy_o && data_bus_oe_n_o)
    else $error("hardware reset not honoured");
  a_lock_refuse: assert property (@(posedge clk_sys_i) disable iff (clr_all)
    (lock_all || outer_blk) |=> !prog_grant_o)
    else $error("program granted while locked");
endmodule : bfp_port
`default_nettype wire

// ===== tb/bfp_link_host.sv
// Host-side link clock model that runs only while a burst frame is open
`timescale 1ns/1ps
`default_nettype none
module bfp_link_host (
  input  wire logic run_i,
  output logic      link_clk_o
);
  // Clock stands still low between frames, phase unrelated to the system clock
  initial link_clk_o = 1'b0;
  always
  begin
    wait (run_i);
    #13;
    while (run_i)
    begin
      #40 link_clk_o = ~link_clk_o;
    end
    link_clk_o = 1'b0;
  end
endmodule : bfp_link_host
`default_nettype wire

// ===== tb/burst_flash_host_port_tb.sv
// Self-checking bench for the burst flash host port
`timescale 1ns/1ps
`default_nettype none
module burst_flash_host_port_tb;
  import bfp_pkg::*;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, run = 1'b0, ce_n = 1'b1, oe_n = 1'b1;
  logic addr_valid_strobe_n = 1'b1, hrst_n = 1'b1, wp_n = 1'b1, burst_mode = 1'b0;
  logic prog_req = 1'b0, prog_outer = 1'b0, we_n = 1'b1;
  logic [1:0]  acc = 2'h1;
  logic [20:0] word_addr = 21'h000000, array_addr, a;
  logic [15:0] data_bus;
  logic        data_oe_n, rdy, read_array, grant, accel, bypass;
  wire logic   link_clk;
  int          err_count = 0, total_checks = 0, link_edges = 0, seed = 32'h25CCF955;

  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge link_clk) link_edges++;

  // Array content is a simple function of the address so data can be predicted
  function automatic logic [15:0] exp_data(input logic [20:0] x);
    return x[15:0] ^ 16'hA5C3;
  endfunction

  bfp_link_host host (.run_i(run), .link_clk_o(link_clk));

  bfp_port dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link_clk_i(link_clk), .chip_en_n_i(ce_n),
    .out_en_n_i(oe_n), .write_en_n_i(we_n), .addr_valid_strobe_n_i(addr_valid_strobe_n),
    .word_addr_i(word_addr), .hw_reset_n_i(hrst_n), .write_protect_n_i(wp_n),
    .acc_level_i(acc), .burst_mode_i(burst_mode), .array_rdata_i(exp_data(array_addr)),
    .prog_req_i(prog_req), .prog_outer_i(prog_outer), .array_addr_o(array_addr),
    .data_bus_o(data_bus), .data_bus_oe_n_o(data_oe_n), .rdy_o(rdy),
    .read_array_o(read_array), .prog_grant_o(grant), .prog_accel_o(accel),
    .unlock_bypass_o(bypass));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // One burst: load start, count link edges to ready, step once, end by chip enable
  task automatic burst(input logic [20:0] s);
    int lat;
    int n;
    lat = (s[0] == 1'b0) ? int'(LAT_RED_EDGES) : int'(LAT_STD_EDGES);
    n = 0;
    ce_n = 1'b0;
    oe_n = 1'b0;
    word_addr = s;
    addr_valid_strobe_n = 1'b0;
    cyc(4);
    addr_valid_strobe_n = 1'b1;
    cyc(1); // Address held past the strobe's rising edge
    word_addr = ~s; // Must be ignored while the strobe is high
    cyc(4);
    chk(rdy, 1'b0, "ready before data");
    link_edges = 0;
    run = 1'b1;
    while (rdy !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    if (n >= 400)
    begin
      err_count++;
      test_done();
    end
    chk(link_edges, lat, "initial latency");
    chk(array_addr, s, "burst start");
    cyc(1);
    chk(data_bus, exp_data(s), "first word");
    @(posedge link_clk);
    cyc(6);
    chk(array_addr, 21'(s + 21'h000001), "burst step");
    chk(rdy, 1'b1, "ready in data phase");
    ce_n = 1'b1;
    cyc(5);
    chk(rdy, 1'b0, "burst ended");
    run = 1'b0;
    oe_n = 1'b1;
    cyc(12);
  endtask

  initial
  begin
    cyc(6);
    chk(read_array, 1'b1, "idle in reset");
    chk(data_oe_n, 1'b1, "bus released in reset");
    cyc(6);
    rst_i = 1'b0;
    cyc(2);
    // Asynchronous read with the link clock standing still
    a = 21'($random(seed));
    ce_n = 1'b0;
    oe_n = 1'b0;
    word_addr = a;
    addr_valid_strobe_n = 1'b0;
    cyc(6);
    chk(array_addr, a, "async address");
    chk(data_bus, exp_data(a), "async data");
    chk(data_oe_n, 1'b0, "bus driven on read");
    we_n = 1'b0;
    cyc(5);
    chk(data_oe_n, 1'b1, "bus released on write");
    we_n = 1'b1;
    addr_valid_strobe_n = 1'b1;
    cyc(5);
    word_addr = ~a;
    cyc(6);
    chk(array_addr, a, "address ignored");
    oe_n = 1'b1;
    cyc(5);
    chk(data_oe_n, 1'b1, "output gated");
    ce_n = 1'b1;
    burst_mode = 1'b1;
    cyc(4);
    a[0] = 1'b0;
    burst(a);
    a = 21'($random(seed));
    a[0] = 1'b1;
    burst(a);
    // Every acceleration level against write protect and sector position
    prog_req = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      acc = 2'(i % 3);
      wp_n = 1'((i / 3) % 2);
      prog_outer = 1'(i / 6);
      cyc(5);
      chk(grant, (acc != 2'h0) && !(wp_n == 1'b0 && prog_outer), "grant");
      chk(accel, acc == 2'h2, "accelerate");
      chk(bypass, acc == 2'h2, "unlock bypass");
    end
    hrst_n = 1'b0;
    cyc(6);
    chk(read_array, 1'b1, "hardware reset");
    chk(rdy, 1'b0, "ready cleared");
    test_done();
  end
endmodule : burst_flash_host_port_tb
`default_nettype wire
